// ==== rtl/ubk_match_if.sv ====
// Break condition and observed bus cycle between top and matcher
`timescale 1ns/1ps
`default_nettype none
interface ubk_match_if;
  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic [7:0] cond;
  logic cyc_valid;
  logic [31:0] cyc_addr;
  logic cyc_dma;
  logic cyc_fetch;
  logic cyc_write;
  logic [1:0] cyc_size;
  logic match;
  modport host (
    output brk_addr, brk_mask, cond, cyc_valid, cyc_addr,
    output cyc_dma, cyc_fetch, cyc_write, cyc_size,
    input match
  );
  modport matcher (
    input brk_addr, brk_mask, cond, cyc_valid, cyc_addr,
    input cyc_dma, cyc_fetch, cyc_write, cyc_size,
    output match
  );
endinterface : ubk_match_if
`default_nettype wire

// ==== rtl/ubk_matcher.sv ====
// Combinational compare of one bus cycle against the break condition
`timescale 1ns/1ps
`default_nettype none
module ubk_matcher
  import ubk_pkg::*;
(
  ubk_match_if.matcher m
);
  logic addr_ok;
  logic master_ok;
  logic type_ok;
  logic dir_ok;
  logic size_ok;
  logic [1:0] eff_size;
  always_comb begin
    addr_ok = ((m.cyc_addr ^ m.brk_addr) & ~m.brk_mask) == 32'h0000_0000;
    master_ok = m.cyc_dma ? m.cond[COND_MASTER_DMA] : m.cond[COND_MASTER_CPU];
    type_ok = m.cyc_fetch ? m.cond[COND_TYPE_FETCH] : m.cond[COND_TYPE_DATA];
    dir_ok = m.cyc_write ? m.cond[COND_DIR_WRITE] : m.cond[COND_DIR_READ];
    eff_size = m.cyc_fetch ? SIZE_WORD : m.cyc_size;
    size_ok = (m.cond[COND_SIZE_HI:COND_SIZE_LO] == SIZE_ANY) ||
              (m.cond[COND_SIZE_HI:COND_SIZE_LO] == eff_size);
    m.match = m.cyc_valid & addr_ok & master_ok & type_ok & dir_ok & size_ok;
  end
endmodule // ubk_matcher
`default_nettype wire

// ==== rtl/ubk_pkg.sv ====
// Constants shared by the user break matcher files
package ubk_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_ADDR_HI = 8'h00;
  localparam logic [7:0] OFS_ADDR_LO = 8'h04;
  localparam logic [7:0] OFS_MASK_HI = 8'h08;
  localparam logic [7:0] OFS_MASK_LO = 8'h0c;
  localparam logic [7:0] OFS_COND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_HIT_ADDR = 8'h18;
  // Reset values
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [7:0] RST_COND = 8'h00;
  // Condition field positions
  localparam int COND_MASTER_DMA = 7;
  localparam int COND_MASTER_CPU = 6;
  localparam int COND_TYPE_DATA = 5;
  localparam int COND_TYPE_FETCH = 4;
  localparam int COND_DIR_WRITE = 3;
  localparam int COND_DIR_READ = 2;
  localparam int COND_SIZE_HI = 1;
  localparam int COND_SIZE_LO = 0;
  // Operand size codes
  localparam logic [1:0] SIZE_ANY = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;
  // Status field positions
  localparam int STAT_PENDING = 0;
  localparam int STAT_STANDBY = 1;
  localparam int STAT_HITS_LO = 16;
  // Interrupt priority of the break request
  localparam logic [3:0] BREAK_LEVEL = 4'hf;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ubk_pkg

// ==== rtl/ubk_top.sv ====
// User break condition matcher with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module ubk_top
  import ubk_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // AXI4-Lite write address
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Observed bus cycle
  input wire logic i_cyc_valid,
  input wire logic [31:0] i_cyc_addr,
  input wire logic i_cyc_dma,
  input wire logic i_cyc_fetch,
  input wire logic i_cyc_write,
  input wire logic [1:0] i_cyc_size,
  // Power and interrupt controller
  input wire logic i_standby,
  input wire logic i_break_ack,
  output logic o_break_req,
  output logic [3:0] o_break_level
);

  typedef struct packed {
    logic [15:0] addr_hi;
    logic [15:0] addr_lo;
    logic [15:0] mask_hi;
    logic [15:0] mask_lo;
    logic [7:0] cond;
    logic pending;
    logic [3:0] level;
    logic [15:0] hits;
    logic [31:0] hit_addr;
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ubk_state_t;

  localparam ubk_state_t ST_RESET = '{
    addr_hi: RST_HALF,
    addr_lo: RST_HALF,
    mask_hi: RST_HALF,
    mask_lo: RST_HALF,
    cond: RST_COND,
    pending: 1'b0,
    level: BREAK_LEVEL,
    hits: 16'h0000,
    hit_addr: 32'h0000_0000,
    awready: 1'b0,
    wready: 1'b0,
    aw_full: 1'b0,
    w_full: 1'b0,
    aw_addr: 8'h00,
    wdata: 32'h0000_0000,
    wstrb: 4'h0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: RESP_OKAY
  };

  logic [1:0] rst_pipe;
  logic rst_n;
  ubk_state_t st;
  ubk_state_t next_st;
  logic do_write;
  logic do_read;
  logic write_ok;
  logic [31:0] rd_word;
  logic rd_ok;
  logic aw_take;
  logic w_take;
  logic b_done;
  logic r_done;

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  ubk_match_if mif ();

  assign mif.brk_addr = {st.addr_hi, st.addr_lo};
  assign mif.brk_mask = {st.mask_hi, st.mask_lo};
  assign mif.cond = st.cond;
  assign mif.cyc_valid = i_cyc_valid;
  assign mif.cyc_addr = i_cyc_addr;
  assign mif.cyc_dma = i_cyc_dma;
  assign mif.cyc_fetch = i_cyc_fetch;
  assign mif.cyc_write = i_cyc_write;
  assign mif.cyc_size = i_cyc_size;

  ubk_matcher u_matcher (
    .m (mif.matcher)
  );

  // Merge enabled byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (i_s_axi_araddr)
      OFS_ADDR_HI: begin
        rd_word[15:0] = st.addr_hi;
      end
      OFS_ADDR_LO: begin
        rd_word[15:0] = st.addr_lo;
      end
      OFS_MASK_HI: begin
        rd_word[15:0] = st.mask_hi;
      end
      OFS_MASK_LO: begin
        rd_word[15:0] = st.mask_lo;
      end
      OFS_COND: begin
        rd_word[7:0] = st.cond;
      end
      OFS_STATUS: begin
        rd_word[STAT_PENDING] = st.pending;
        rd_word[STAT_STANDBY] = i_standby;
        rd_word[STAT_HITS_LO +: 16] = st.hits;
      end
      OFS_HIT_ADDR: begin
        rd_word = st.hit_addr;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Next state
  always_comb begin
    next_st = st;
    write_ok = 1'b1;
    do_write = st.aw_full & st.w_full & ~st.bvalid;
    do_read = i_s_axi_arvalid & st.arready;
    aw_take = i_s_axi_awvalid & st.awready;
    w_take = i_s_axi_wvalid & st.wready;
    b_done = st.bvalid & i_s_axi_bready;
    r_done = st.rvalid & i_s_axi_rready;

    // Write address and data, taken in either order
    if (aw_take) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = i_s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_full = 1'b1;
      next_st.wdata = i_s_axi_wdata;
      next_st.wstrb = i_s_axi_wstrb;
    end

    // Register update once both halves are held
    if (do_write) begin
      unique case (st.aw_addr)
        OFS_ADDR_HI: begin
          next_st.addr_hi = merge16(st.addr_hi, st.wdata, st.wstrb);
        end
        OFS_ADDR_LO: begin
          next_st.addr_lo = merge16(st.addr_lo, st.wdata, st.wstrb);
        end
        OFS_MASK_HI: begin
          next_st.mask_hi = merge16(st.mask_hi, st.wdata, st.wstrb);
        end
        OFS_MASK_LO: begin
          next_st.mask_lo = merge16(st.mask_lo, st.wdata, st.wstrb);
        end
        OFS_COND: begin
          if (st.wstrb[0]) begin
            next_st.cond = st.wdata[7:0];
          end
        end
        OFS_STATUS, OFS_HIT_ADDR: begin
          write_ok = 1'b1;
        end
        default: begin
          write_ok = 1'b0;
        end
      endcase
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = write_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      next_st.bvalid = 1'b0;
      next_st.bresp = RESP_OKAY;
    end

    // Read answer one edge after the address is taken
    if (do_read) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      next_st.rvalid = 1'b0;
      next_st.rdata = 32'h0000_0000;
      next_st.rresp = RESP_OKAY;
    end

    // One write and one read under way at a time
    next_st.awready = ~next_st.aw_full & ~next_st.bvalid;
    next_st.wready = ~next_st.w_full & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;

    // pending until acknowledged; a new match wins over the ack
    next_st.pending = (st.pending & ~i_break_ack) | mif.match;
    next_st.level = BREAK_LEVEL;
    if (mif.match) begin
      next_st.hits = st.hits + 16'h0001;
      next_st.hit_addr = i_cyc_addr;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_s_axi_awready = st.awready;
  assign o_s_axi_wready = st.wready;
  assign o_s_axi_bresp = st.bresp;
  assign o_s_axi_bvalid = st.bvalid;
  assign o_s_axi_arready = st.arready;
  assign o_s_axi_rdata = st.rdata;
  assign o_s_axi_rresp = st.rresp;
  assign o_s_axi_rvalid = st.rvalid;
  assign o_break_req = st.pending;
  assign o_break_level = st.level;

endmodule // ubk_top
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the user break matcher
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ubk_pkg::*;
  logic i_ref_clk, i_rstn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready, i_cyc_valid, i_cyc_dma, i_cyc_fetch;
  logic i_cyc_write, i_standby, i_break_ack, hold, seen;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_break_req;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, c;
  logic [31:0] i_s_axi_wdata, i_cyc_addr, o_s_axi_rdata, ba, bm, ca;
  logic [3:0] i_s_axi_wstrb, o_break_level;
  logic [1:0] i_cyc_size, o_s_axi_bresp, o_s_axi_rresp;
  logic [4:0] k;
  logic [33:0] q_bus[$];
  logic q_brk[$];
  int failures, n_compared, nh;
  ubk_top ubk_top_i (.*);
  ubk_bus_model ubk_bus_model_i (.i_clk(i_ref_clk), .i_req(o_break_req), .i_hold(hold),
    .o_valid(i_cyc_valid), .o_addr(i_cyc_addr), .o_ack(i_break_ack),
    .o_kind({i_cyc_dma, i_cyc_fetch, i_cyc_write, i_cyc_size}));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q_bus.push_back({r, 32'h0});
    @(posedge i_ref_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q_bus.push_back(e);
    @(posedge i_ref_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'b0;
  endtask
  function automatic logic hit(input logic [7:0] c, input logic [31:0] a, input logic [4:0] k);
    logic [1:0] s;
    s = k[3] ? SIZE_WORD : k[1:0];
    return c[6 + k[4]] && c[5 - k[3]] && c[2 + k[2]] && ((a ^ ba) & ~bm) == 32'h0
      && (c[1:0] == SIZE_ANY || c[1:0] == s);
  endfunction
  always @(posedge i_ref_clk) begin
    if (o_s_axi_bvalid && i_s_axi_bready) chk({o_s_axi_bresp, 32'h0}, q_bus.pop_front());
    if (o_s_axi_rvalid && i_s_axi_rready) chk({o_s_axi_rresp, o_s_axi_rdata}, q_bus.pop_front());
    if (seen) chk({33'h0, o_break_req}, {33'h0, q_brk.pop_front()});
    seen = i_cyc_valid;
  end
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    give_verdict();
  end
  initial begin
    {i_rstn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_standby} = '0;
    {i_s_axi_arvalid, i_s_axi_rready, i_s_axi_awaddr, i_s_axi_araddr} = '0;
    i_s_axi_wdata = 32'h0;
    i_s_axi_wstrb = 4'hf;
    {failures, n_compared, nh} = '0;
    seen = 1'b0;
    hold = 1'b1;
    void'($urandom(32'he3dc2357));
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 34'h0);
    ba = $urandom;
    bm = $urandom & $urandom & $urandom;
    i_standby <= 1'b1;
    wr(OFS_ADDR_HI, {16'h0, ba[31:16]}, RESP_OKAY);
    wr(OFS_ADDR_LO, {16'hffff, ba[15:0]}, RESP_OKAY);
    wr(OFS_MASK_HI, {16'h0, bm[31:16]}, RESP_OKAY);
    wr(OFS_MASK_LO, {16'h0, bm[15:0]}, RESP_OKAY);
    i_s_axi_wstrb <= 4'h2;
    bm[31:24] = 8'ha5;
    wr(OFS_MASK_HI, 32'h5a5a_a5a5, RESP_OKAY);
    i_s_axi_wstrb <= 4'hf;
    wr(OFS_COND, 32'hffff_ffff, RESP_OKAY);
    wr(8'h1c, 32'h0, RESP_SLVERR);
    rd(OFS_ADDR_HI, {RESP_OKAY, 16'h0, ba[31:16]});
    rd(OFS_ADDR_LO, {RESP_OKAY, 16'h0, ba[15:0]});
    rd(OFS_MASK_HI, {RESP_OKAY, 16'h0, bm[31:16]});
    rd(OFS_MASK_LO, {RESP_OKAY, 16'h0, bm[15:0]});
    rd(OFS_COND, {RESP_OKAY, 24'h0, 8'hff});
    rd(OFS_STATUS, {RESP_OKAY, 16'h0, 16'h2});
    i_standby <= 1'b0;
    for (int i = 0; i < 81; i++) begin
      c = (i == 80) ? 8'hfc : 8'($urandom);
      k = (i == 80) ? 5'h01 : 5'($urandom);
      if (c[4]) c[0] = 1'b0;
      if (k[4]) k[3] = 1'b0;
      if (k[1:0] == SIZE_ANY) k[1:0] = SIZE_LONG;
      ca = i[0] ? $urandom : ba ^ ($urandom & bm);
      wr(OFS_COND, {24'h0, c}, RESP_OKAY);
      q_brk.push_back(hit(c, ca, k));
      nh += int'(hit(c, ca, k));
      ubk_bus_model_i.cycle(ca, k);
      @(posedge i_ref_clk);
      if (i == 80) repeat (20) @(posedge i_ref_clk);
      if (i == 80) rd(OFS_STATUS, {RESP_OKAY, 16'(nh), 16'h1});
      if (i == 80) rd(OFS_HIT_ADDR, {RESP_OKAY, ca});
      hold <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      hold <= 1'b1;
    end
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ==== testbench/ubk_bus_model.sv ====
// Bus cycle source and interrupt controller around the matcher
`timescale 1ns/1ps
`default_nettype none
module ubk_bus_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_hold,
  output logic o_valid,
  output logic [31:0] o_addr,
  output logic [4:0] o_kind,
  output logic o_ack
);
  initial begin
    o_valid = 1'b0;
    o_addr = 32'h0;
    o_kind = 5'h0;
  end
  task automatic cycle(input logic [31:0] a, input logic [4:0] k);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_addr <= a;
    o_kind <= k;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    o_kind <= ~k;
  endtask
  always @(posedge i_clk) o_ack <= i_req && !i_hold && !o_ack;
endmodule // ubk_bus_model
`default_nettype wire

// ==== testbench/ubk_top_sva.sv ====
// Port assertions for the user break matcher
`timescale 1ns/1ps
`default_nettype none
module ubk_top_sva
  import ubk_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_cyc_valid,
  input wire logic i_break_ack,
  input wire logic o_break_req,
  input wire logic [3:0] o_break_level
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !o_s_axi_bvalid ##1 o_s_axi_bvalid;
  endsequence
  AST_LEVEL: assert property (o_break_req |-> o_break_level == BREAK_LEVEL)
    else $error("bad break level");
  AST_PEND: assert property (o_break_req && !i_break_ack |=> o_break_req)
    else $error("pending break lost");
  AST_ACK: assert property (o_break_req && i_break_ack && !i_cyc_valid |=> !o_break_req)
    else $error("break not cleared");
  AST_IDLE: assert property (!o_break_req && !i_cyc_valid |=> !o_break_req)
    else $error("break without bus cycle");
  AST_WR: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write answer timing");
  AST_RD: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  AST_BEND: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write answer stuck");
  AST_REND: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read answer stuck");
endmodule // ubk_top_sva
bind ubk_top ubk_top_sva ubk_top_sva_i (.*);
`default_nettype wire
